// >>> rtl/scrb_config_bank.sv
// Serial slave with the general configuration registers.
// Assumes serial pins asynchronous to core_clk, clock idle low, mode 0.
`timescale 1ns/1ns
`include "scrb_defs.svh"

module scrb_config_bank #(
   parameter logic [3:0] DEV_CLASS = 4'h5  // Arbitrary value
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic spi_cs_n,
   input  wire logic spi_sclk,
   input  wire logic spi_sdi,
   output logic      serial_out_pin,
   output logic      serial_out_oe_n,
   output logic      chip_reset,
   output logic      power_down
);

   // ****************************************
   // Pin synchroniser
   // ****************************************
   scrb_pkg::scrb_pins_s pins_m_q;
   scrb_pkg::scrb_pins_s pins_s_q;
   logic                 sclk_d_q;
   logic                 rise;
   logic                 fall;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_m_q <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
         pins_s_q <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
         sclk_d_q <= 1'b0;
      end else begin
         pins_m_q <= '{cs_n: spi_cs_n, sclk: spi_sclk, sdi: spi_sdi};
         pins_s_q <= pins_m_q;
         sclk_d_q <= pins_s_q.sclk;
      end
   end

   assign rise = pins_s_q.sclk & ~sclk_d_q;
   assign fall = ~pins_s_q.sclk & sclk_d_q;

   // ****************************************
   // Registers and decode
   // ****************************************
   logic [7:0]  ifc_q;
   logic [7:0]  mode_q;
   logic [3:0]  class_hi_q;
   logic [7:0]  usr_q;
   logic [5:0]  busy_cnt_q;
   logic        busy_q;
   scrb_pkg::scrb_state_e st_q;
   logic [3:0]  cnt_q;
   logic [14:0] sh_q;
   logic        rd_q;
   logic [14:0] addr_q;
   logic [7:0]  rsh_q;
   logic [6:0]  wsh_q;
   logic        xfer_ok;
   logic        byte_end;
   logic        wr_en;
   logic [7:0]  wr_data;
   logic        srst_fire;

   function automatic logic [7:0] rd_reg(input logic [14:0] a);
      case (a)
         `SCRB_ADDR_IFC:   rd_reg = ifc_q;
         `SCRB_ADDR_MODE:  rd_reg = mode_q;
         `SCRB_ADDR_CLASS: rd_reg = {class_hi_q, DEV_CLASS};
         `SCRB_ADDR_USR:   rd_reg = usr_q;
         default:          rd_reg = 8'h00;
      endcase
   endfunction : rd_reg

   function automatic logic [14:0] step(input logic [14:0] a);
      if (usr_q[`SCRB_HOLD_BIT])
         step = a;
      else if (ifc_q[`SCRB_ASCEND_BIT])
         step = 15'(a + 15'h0001);
      else
         step = 15'(a - 15'h0001);
   endfunction : step

   assign xfer_ok   = !busy_q && !pins_s_q.cs_n;
   assign byte_end  = xfer_ok && (st_q == scrb_pkg::ST_DATA) && rise && (cnt_q == 4'h7);
   assign wr_en     = byte_end && !rd_q;
   assign wr_data   = {wsh_q, pins_s_q.sdi};
   assign srst_fire = wr_en && (addr_q == `SCRB_ADDR_IFC) && wr_data[`SCRB_SRST_BIT];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ifc_q      <= `SCRB_IFC_RST;
         mode_q     <= `SCRB_MODE_RST;
         class_hi_q <= `SCRB_CLASS_HI_RST;
         usr_q      <= `SCRB_USR_RST;
      end else if (srst_fire) begin
         ifc_q      <= `SCRB_IFC_RST;
         mode_q     <= `SCRB_MODE_RST;
         class_hi_q <= `SCRB_CLASS_HI_RST;
         usr_q      <= `SCRB_USR_RST;
      end else if (wr_en) begin
         case (addr_q)
            `SCRB_ADDR_IFC:   ifc_q <= {1'b0, wr_data[6:5], 1'b1, wr_data[3:0]};
            `SCRB_ADDR_MODE:  mode_q <= wr_data;
            `SCRB_ADDR_CLASS: class_hi_q <= wr_data[7:4];
            `SCRB_ADDR_USR:   usr_q <= wr_data;
            default:          usr_q <= usr_q;
         endcase
      end
   end

   // ****************************************
   // Soft reset timer
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_q <= 6'h00;
         busy_q     <= 1'b0;
      end else begin
         if (srst_fire)
            busy_cnt_q <= 6'(`SCRB_SRST_CYC);
         else if (busy_cnt_q != 6'h00)
            busy_cnt_q <= busy_cnt_q - 6'h01;
         busy_q <= srst_fire || (busy_cnt_q > 6'h01);
      end
   end

   // ****************************************
   // Serial frame engine
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= scrb_pkg::ST_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= 15'h0000;
         rd_q   <= 1'b0;
         addr_q <= 15'h0000;
         rsh_q  <= 8'h00;
         wsh_q  <= 7'h00;
      end else if (!xfer_ok) begin
         st_q  <= scrb_pkg::ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (st_q)
            scrb_pkg::ST_IDLE: begin
               st_q  <= scrb_pkg::ST_CMD;
               cnt_q <= 4'h0;
            end
            scrb_pkg::ST_CMD: begin
               if (rise) begin
                  sh_q  <= {sh_q[13:0], pins_s_q.sdi};
                  cnt_q <= 4'(cnt_q + 4'h1);
                  if (cnt_q == 4'hF) begin
                     rd_q   <= sh_q[14];
                     addr_q <= {sh_q[13:0], pins_s_q.sdi};
                     rsh_q  <= rd_reg({sh_q[13:0], pins_s_q.sdi});
                     st_q   <= scrb_pkg::ST_DATA;
                     cnt_q  <= 4'h0;
                  end
               end
            end
            scrb_pkg::ST_DATA: begin
               if (rise) begin
                  wsh_q <= wr_data[6:0];
                  cnt_q <= 4'(cnt_q + 4'h1);
                  if (cnt_q == 4'h7) begin
                     cnt_q  <= 4'h0;
                     addr_q <= step(addr_q);
                     rsh_q  <= rd_reg(step(addr_q));
                  end
               end else if (fall) begin
                  rsh_q <= {rsh_q[6:0], 1'b0};
               end
            end
            default: st_q <= scrb_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_out_pin  <= 1'b0;
         serial_out_oe_n <= 1'b1;
      end else if (xfer_ok && st_q == scrb_pkg::ST_DATA && rd_q) begin
         serial_out_oe_n <= 1'b0;
         if (fall)
            serial_out_pin <= rsh_q[7];
      end else begin
         serial_out_oe_n <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_down <= 1'b0;
         chip_reset <= 1'b0;
      end else begin
         power_down <= (mode_q[1:0] == `SCRB_MODE_PD);
         chip_reset <= srst_fire || (busy_cnt_q > 6'h01);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_busy_run;
      busy_q [*8];
   endsequence

   AST_SRST_DEFAULTS: assert property (srst_fire |=> ifc_q == 8'h30 && mode_q == 8'h00 && usr_q == 8'h00)
      else $error("Soft reset left a register off its default");
   AST_SRST_SELFCLR: assert property (!ifc_q[7])
      else $error("Soft reset bit stayed set");
   AST_SRST_BUSY: assert property (srst_fire |=> s_busy_run)
      else $error("Soft reset window too short");
   AST_SRST_END: assert property (srst_fire |-> ##38 !busy_q)
      else $error("Soft reset window exceeds 750 ns");
   AST_QUIET_BUSY: assert property (busy_q |=> st_q == scrb_pkg::ST_IDLE)
      else $error("Frame engine ran during soft reset");
   AST_RDPIN_ONE: assert property (ifc_q[4] && rd_reg(`SCRB_ADDR_CLASS) == {class_hi_q, DEV_CLASS})
      else $error("Read-only field changed");
   AST_OE_READ: assert property (!serial_out_oe_n |-> rd_q)
      else $error("Output driven outside a read");
   AST_MODE_PD: assert property (mode_q[1:0] == 2'h3 |=> power_down)
      else $error("Power down not entered");
   AST_MODE_RUN: assert property (mode_q[1:0] != 2'h3 |=> !power_down)
      else $error("Power down outside mode three");
   AST_ADDR_UP: assert property (byte_end && !usr_q[0] && ifc_q[5] |=> addr_q == 15'($past(addr_q) + 15'h0001))
      else $error("Address did not increment");
   AST_ADDR_DOWN: assert property (byte_end && !usr_q[0] && !ifc_q[5] |=> addr_q == 15'($past(addr_q) - 15'h0001))
      else $error("Address did not decrement");
   AST_ADDR_HOLD: assert property (byte_end && usr_q[0] |=> $stable(addr_q))
      else $error("Address moved while frozen");

endmodule : scrb_config_bank

// >>> rtl/scrb_defs.svh
// Constants of the serial configuration register bank.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef SCRB_DEFS_SVH
`define SCRB_DEFS_SVH

`define SCRB_ADDR_IFC      15'h0000
`define SCRB_ADDR_MODE     15'h0002
`define SCRB_ADDR_CLASS    15'h0003
`define SCRB_ADDR_USR      15'h0010

`define SCRB_SRST_BIT      7
`define SCRB_ASCEND_BIT    5
`define SCRB_RDPIN_BIT     4
`define SCRB_HOLD_BIT      0

`define SCRB_IFC_RST       8'h30
`define SCRB_MODE_RST      8'h00
`define SCRB_CLASS_HI_RST  4'h0
`define SCRB_USR_RST       8'h00
`define SCRB_MODE_PD       2'h3

`define SCRB_SRST_NS       750
`define SCRB_CLK_NS        20
`define SCRB_SRST_CYC      (`SCRB_SRST_NS / `SCRB_CLK_NS)

`endif

// >>> rtl/scrb_pkg.sv
// Types of the serial configuration register bank.
// Constants live in scrb_defs.svh.
package scrb_pkg;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdi;
   } scrb_pins_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD  = 2'b01,
      ST_DATA = 2'b11
   } scrb_state_e;

endpackage : scrb_pkg

// >>> sim/scrb_host.sv
// Far-side serial host model for the configuration bank.
// Assumes core_clk at 50 MHz; sclk period 8 cycles.
`timescale 1ns/1ns
module scrb_host (
   input  wire logic           core_clk,
   output scrb_pkg::scrb_pins_s pins,
   input  wire logic           serial_out_pin,
   input  wire logic           serial_out_oe_n
);
   logic oe_bad;
   initial begin
      pins   = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
      oe_bad = 1'b0;
   end
   // ****************
   // One frame: command then n bytes
   // ****************
   task automatic xfer(input logic rw, input logic [14:0] adr, input int n, input logic [31:0] wd,
                       output logic [31:0] rd);
      logic [47:0] sh;
      sh = {rw, adr, wd};
      rd = 32'h0000_0000;
      @(posedge core_clk) pins.cs_n <= 1'b0;
      for (int i = 0; i < 16 + 8 * n; i++) begin
         @(posedge core_clk) pins.sdi <= sh[47 - i];
         repeat (4) @(posedge core_clk);
         if (i >= 16) begin
            rd = {rd[30:0], serial_out_pin};
            if (rw && serial_out_oe_n !== 1'b0) oe_bad = 1'b1;
         end
         pins.sclk <= 1'b1;
         repeat (3) @(posedge core_clk);
         pins.sclk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      pins.cs_n <= 1'b1;
      pins.sdi  <= ~pins.sdi;
      // Idle gap so the deselect passes the pin synchroniser
      repeat (4) @(posedge core_clk);
   endtask : xfer
endmodule : scrb_host

// >>> sim/tb.sv
// Self-checking bench of the configuration bank.
// Assumes scrb_host as the far-side serial master.
`timescale 1ns/1ns
`include "scrb_defs.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s exp %h got %h", nm, ex, got); end end
module tb;
   localparam logic [3:0] CLS = 4'h9; // Arbitrary value
   logic                 core_clk = 1'b0;
   logic                 rst_n = 1'b0;
   scrb_pkg::scrb_pins_s pins;
   logic                 sout, oe_n, chip_reset, power_down;
   int                   fail_count = 0;
   int                   total_checks = 0;
   int                   rst_len = 0;
   int                   rst_base = 0;
   logic [31:0]          seed = 32'h2754_1123;
   logic [31:0]          r;
   logic [7:0]           v, d;
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) if (chip_reset === 1'b1) rst_len <= rst_len + 1;
   scrb_config_bank #(.DEV_CLASS(CLS)) u_scrb_config_bank (.core_clk(core_clk), .rst_n(rst_n),
      .spi_cs_n(pins.cs_n), .spi_sclk(pins.sclk), .spi_sdi(pins.sdi), .serial_out_pin(sout),
      .serial_out_oe_n(oe_n), .chip_reset(chip_reset), .power_down(power_down));
   scrb_host u_scrb_host (.core_clk(core_clk), .pins(pins), .serial_out_pin(sout), .serial_out_oe_n(oe_n));
   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic end_sim();
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic wr(input logic [14:0] a, input logic [7:0] x);
      u_scrb_host.xfer(1'b0, a, 1, {x, 24'h00_0000}, r);
   endtask : wr
   task automatic rd(input logic [14:0] a, output logic [7:0] x);
      u_scrb_host.xfer(1'b1, a, 1, 32'h0000_0000, r);
      x = r[7:0];
   endtask : rd
   task automatic wait_pd(input logic e);
      for (int i = 0; i < 16 && power_down !== e; i++) @(posedge core_clk);
      `CHK("power_down", e, power_down)
      if (power_down !== e) end_sim();
   endtask : wait_pd
   task automatic chk_rst();
      logic [7:0]  ex [4];
      logic [14:0] ad [4];
      ex = '{`SCRB_IFC_RST, `SCRB_MODE_RST, {`SCRB_CLASS_HI_RST, CLS}, `SCRB_USR_RST};
      ad = '{`SCRB_ADDR_IFC, `SCRB_ADDR_MODE, `SCRB_ADDR_CLASS, `SCRB_ADDR_USR};
      for (int i = 0; i < 4; i++) begin
         rd(ad[i], d);
         `CHK("reset value", ex[i], d)
      end
      wait_pd(1'b0);
   endtask : chk_rst
   // ****************
   // Main sequence
   // ****************
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      chk_rst();
      rd(15'h0007, d);
      `CHK("unmapped", 8'h00, d)
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         v = seed[7:0];
         wr(`SCRB_ADDR_IFC, {1'b0, v[6:0]});
         rd(`SCRB_ADDR_IFC, d);
         `CHK("ifc", {1'b0, v[6:5], 1'b1, v[3:0]}, d)
         wr(`SCRB_ADDR_CLASS, v);
         rd(`SCRB_ADDR_CLASS, d);
         `CHK("class", {v[7:4], CLS}, d)
         wr(`SCRB_ADDR_MODE, {6'h00, {2{v[0]}}});
         wait_pd(v[0]);
      end
      wr(`SCRB_ADDR_IFC, 8'h30);
      u_scrb_host.xfer(1'b0, `SCRB_ADDR_MODE, 2, {8'h03, 8'hA0, 16'h0000}, r);
      u_scrb_host.xfer(1'b1, `SCRB_ADDR_MODE, 2, 32'h0000_0000, r);
      `CHK("ascend", {8'h03, 4'hA, CLS}, r[15:0])
      wr(`SCRB_ADDR_IFC, 8'h10);
      u_scrb_host.xfer(1'b1, `SCRB_ADDR_CLASS, 2, 32'h0000_0000, r);
      `CHK("descend", {4'hA, CLS, 8'h03}, r[15:0])
      wr(`SCRB_ADDR_USR, 8'h01);
      u_scrb_host.xfer(1'b0, `SCRB_ADDR_MODE, 2, {8'h00, 8'h03, 16'h0000}, r);
      u_scrb_host.xfer(1'b1, `SCRB_ADDR_MODE, 2, 32'h0000_0000, r);
      `CHK("freeze", 16'h0303, r[15:0])
      `CHK("oe during reads", 1'b0, u_scrb_host.oe_bad)
      rst_base = rst_len;
      wr(`SCRB_ADDR_IFC, 8'h80);
      repeat (40) @(posedge core_clk);
      `CHK("reset length", 37, rst_len - rst_base)
      `CHK("chip_reset", 1'b0, chip_reset)
      chk_rst();
      repeat (2) @(posedge core_clk);
      `CHK("oe idle", 1'b1, oe_n)
      end_sim();
   end
endmodule : tb
